// ### tsr_pkg.sv
// Package for the timebase, sleep and reset unit: register map, fields, reset values, timing
package tsr_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] TSR_OFS_SHARED_IRQ_CTRL = 4'h0;
  localparam logic [3:0] TSR_OFS_IRQ_CTRL_SECOND = 4'h1;
  localparam logic [3:0] TSR_OFS_PERIODIC_CTRL   = 4'h2;
  localparam logic [3:0] TSR_OFS_STATUS          = 4'h3;
  localparam logic [3:0] TSR_OFS_COMMAND         = 4'h4;
  localparam logic [3:0] TSR_OFS_OPTIONS         = 4'h5;

  // Field positions in the shared interrupt control register
  localparam int TSR_BIT_TICK_EN     = 1;
  localparam int TSR_BIT_PERIODIC_EN = 2;
  localparam int TSR_BIT_TICK_FLAG   = 5;
  localparam int TSR_BIT_PERIODIC_FLAG = 6;
  // Field positions in the second interrupt control register
  localparam int TSR_BIT_SHARED_EN   = 2;
  localparam int TSR_BIT_SHARED_FLAG = 6;
  // Periodic clock control register fields
  localparam int TSR_POS_RATE        = 0;
  localparam int TSR_BIT_FAST_START  = 4;
  // Status register fields
  localparam int TSR_BIT_POWERDOWN   = 0;
  localparam int TSR_BIT_EXPIRED     = 1;
  localparam int TSR_BIT_SLEEPING    = 2;
  localparam int TSR_BIT_STARTING    = 3;
  // Command register bits (write one to act)
  localparam int TSR_BIT_CMD_SLEEP   = 0;
  localparam int TSR_BIT_CMD_WDCLR   = 1;
  // Options register fields
  localparam int TSR_POS_SRC         = 0;
  localparam int TSR_POS_TICKSEL     = 2;
  localparam int TSR_POS_DISPSEL     = 4;
  localparam int TSR_POS_BUZZSEL     = 8;
  localparam int TSR_POS_WDSEL       = 11;
  localparam int TSR_POS_WAKEMASK    = 16;

  // Reset values
  localparam logic [2:0] TSR_RST_RATE    = 3'h7;
  localparam logic [7:0] TSR_RST_OPTIONS_LO = 8'h00;

  // Source clock selection codes
  localparam logic [1:0] TSR_SRC_WDOSC = 2'h0;
  localparam logic [1:0] TSR_SRC_RTOSC = 2'h1;
  localparam logic [1:0] TSR_SRC_INSTR = 2'h2;

  // Chain widths and timing
  localparam int TSR_DIV_STAGES   = 8;
  localparam int TSR_PRE_BITS     = 7;
  localparam int TSR_CHAIN_BITS   = TSR_DIV_STAGES + TSR_PRE_BITS;
  localparam int TSR_INSTR_DIV    = 4;
  localparam int TSR_STARTUP_CYC  = 1024;
  localparam logic [15:0] TSR_RESET_VECTOR = 16'h0000;
  localparam logic [15:0] TSR_IRQ_VECTOR   = 16'h0018;

  // Run state of the core
  typedef enum logic [1:0] {
    TSR_RUN   = 2'b00,
    TSR_SLEEP = 2'b01,
    TSR_START = 2'b10
  } tsr_mode_t;

  // Request toward the processor core
  typedef struct packed {
    logic        hold;
    logic        warmReset;
    logic        irqCall;
    logic [15:0] vector;
  } tsr_core_t;

  // State of the unit, apart from the synchronisers, oscPrev and the port A wake mask
  typedef struct packed {
    tsr_mode_t   mode;
    logic [TSR_CHAIN_BITS-1:0] chain;
    logic [1:0]  instrDiv;
    logic [15:0] wdCount;
    logic [10:0] startCount;
    logic        resumeIrq;
    logic        warm;
    logic        tickEn;
    logic        periodicEn;
    logic        tickFlag;
    logic        periodicFlag;
    logic        sharedEn;
    logic        sharedFlag;
    logic [2:0]  rate;
    logic        fastStart;
    logic        powerdown;
    logic        expired;
    logic [15:0] options;
    logic        pendTickAtSleep;
    logic        pendPerAtSleep;
    logic [7:0]  portAPrev;
    logic [31:0] rdata;
    logic        tickOut;
    logic        periodicOut;
    logic        dispClk;
    logic        buzzClk;
    tsr_core_t   core;
  } tsr_state_t;
endpackage

// ### tsr_unit.sv
// Timebase, sleep and reset unit of the microcontroller
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module tsr_unit
  import tsr_pkg::*;
(
  input  wire logic        mclk,          // System clock, 200 MHz
  input  wire logic        rst,           // Async power-on reset, high
  input  wire logic        wdOscTick,     // Watchdog oscillator edge, async
  input  wire logic        rtOscTick,     // Real-time oscillator edge, async
  input  wire logic        extClearN,     // External clear pin, low active, async
  input  wire logic [7:0]  portA,         // Port A pins, async
  input  wire logic [3:0]  addr,          // Register address
  input  wire logic [31:0] wdata,         // Register write data
  input  wire logic        wr,            // Write strobe
  input  wire logic        rd,            // Read strobe
  output logic      [31:0] rdata,         // Read data, cycle after rd
  output logic             sysOscEnable,  // System oscillator runs
  output logic             fastStartOsc,  // Quick start of 32.768kHz osc
  output logic             tickPulse,     // Tick timeout toward counter 1
  output logic             periodicPulse, // Periodic timeout toward counter 0
  output logic             dispClk,       // Display scan clock
  output logic             buzzClk,       // Buzzer clock
  output logic             coreHold,      // Hold instruction fetch
  output logic             coreWarmReset, // Clear PC and SP only
  output logic             coreIrqCall,   // Call interrupt vector
  output logic      [15:0] coreVector     // Vector for the core
);
  tsr_state_t s;
  tsr_state_t next_s;

  // Two-flop synchronisers for every pin-side input
  logic [10:0] syncA;
  logic [10:0] syncB;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncA <= 11'h7ff;
      syncB <= 11'h7ff;
    end else begin
      syncA <= {extClearN, portA, rtOscTick, wdOscTick};
      syncB <= syncA;
    end
  end

  // Oscillator edge detect on the synchronised copies
  logic [1:0] oscPrev;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      oscPrev <= 2'h3; // Matches synchroniser reset, so no false edge follows reset
    end else begin
      oscPrev <= syncB[1:0];
    end
  end

  logic        wdEdge;
  logic        rtEdge;
  logic        clrLow;
  logic [7:0]  portSync;
  assign wdEdge   = syncB[0] & ~oscPrev[0];
  assign rtEdge   = syncB[1] & ~oscPrev[1];
  assign portSync = syncB[9:2];
  assign clrLow   = ~syncB[10];

  // Source selection and derived conditions
  logic [1:0]  src;
  logic        slowSrc;
  logic        srcTick;
  logic [TSR_CHAIN_BITS-1:0] chainInc;
  logic [TSR_CHAIN_BITS-1:0] chainRise;
  logic [1:0]  tickSel;
  logic [2:0]  dispSel;
  logic [2:0]  buzzSel;
  logic [1:0]  wdSel;
  logic [7:0]  wakeMask;
  logic [7:0]  portSel;
  logic        wdOverflow;
  logic        portWake;
  logic        tickWake;
  logic        perWake;
  logic        irqReady;
  logic        cmdSleep;
  logic        cmdWdClr;
  logic        wrHit;

  assign src      = s.options[TSR_POS_SRC +: 2];
  assign tickSel  = s.options[TSR_POS_TICKSEL +: 2];
  assign dispSel  = s.options[TSR_POS_DISPSEL +: 3];
  assign buzzSel  = s.options[TSR_POS_BUZZSEL +: 3];
  assign wdSel    = s.options[TSR_POS_WDSEL +: 2];
  assign wakeMask = portSel;
  assign slowSrc  = (src == TSR_SRC_WDOSC) || (src == TSR_SRC_RTOSC);
  // Port A wake mask lives apart since options field is 16 bits wide
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      portSel <= 8'h00;
    end else if (wrHit && addr == TSR_OFS_OPTIONS) begin
      portSel <= wdata[TSR_POS_WAKEMASK +: 8];
    end
  end

  // source select
  // Instruction clock stops with the system oscillator in sleep
  always_comb begin
    unique case (src)
      TSR_SRC_WDOSC: srcTick = wdEdge;
      TSR_SRC_RTOSC: srcTick = rtEdge;
      default:       srcTick = (s.instrDiv == 2'(TSR_INSTR_DIV - 1)) && (s.mode != TSR_SLEEP);
    endcase
  end

  assign chainInc  = s.chain + TSR_CHAIN_BITS'(1);
  assign chainRise = chainInc & ~s.chain;
  assign wdOverflow = srcTick && (s.wdCount == ((16'h1000 << wdSel) - 16'h0001));
  assign cmdSleep  = wr && (addr == TSR_OFS_COMMAND) && wdata[TSR_BIT_CMD_SLEEP];
  assign cmdWdClr  = wr && (addr == TSR_OFS_COMMAND) && wdata[TSR_BIT_CMD_WDCLR];
  assign wrHit     = wr && (s.mode == TSR_RUN);

  always_comb begin
    next_s = s;
    next_s.tickOut     = 1'b0;
    next_s.periodicOut = 1'b0;
    next_s.core.irqCall   = 1'b0;
    next_s.core.warmReset = 1'b0;
    next_s.portAPrev   = portSync;
    portWake = 1'b0;
    tickWake = 1'b0;
    perWake  = 1'b0;
    irqReady = 1'b0;

    next_s.instrDiv = s.instrDiv + 2'h1;

    if (srcTick) begin
      next_s.chain = chainInc;
      next_s.wdCount = s.wdCount + 16'h0001;
    end

    // chain keeps running in sleep on slow sources
    next_s.dispClk = s.chain[4'h1 + 4'(dispSel)];
    next_s.buzzClk = s.chain[4'h1 + 4'(buzzSel)];

    // tick on chain bit 11..14 rising
    if (srcTick && chainRise[4'd11 + 4'(tickSel)]) begin
      next_s.tickOut = 1'b1;
      next_s.tickFlag   = 1'b1;
      next_s.sharedFlag = 1'b1;
    end
    if (srcTick && chainRise[4'd7 + 4'(s.rate)]) begin
      next_s.periodicOut = 1'b1;
      next_s.periodicFlag = 1'b1;
      next_s.sharedFlag   = 1'b1;
    end

    // Register writes; hardware sets win over software clears
    // flags cleared by software writes and external clear, the shared flag also by an interrupt call
    if (wrHit && addr == TSR_OFS_SHARED_IRQ_CTRL) begin
      next_s.tickEn       = wdata[TSR_BIT_TICK_EN];
      next_s.periodicEn   = wdata[TSR_BIT_PERIODIC_EN];
      next_s.tickFlag     = next_s.tickFlag & (wdata[TSR_BIT_TICK_FLAG] | next_s.tickOut);
      next_s.periodicFlag = next_s.periodicFlag & (wdata[TSR_BIT_PERIODIC_FLAG] | next_s.periodicOut);
    end
    if (wrHit && addr == TSR_OFS_IRQ_CTRL_SECOND) begin
      next_s.sharedEn   = wdata[TSR_BIT_SHARED_EN];
      next_s.sharedFlag = next_s.sharedFlag & (wdata[TSR_BIT_SHARED_FLAG] | next_s.tickOut | next_s.periodicOut);
    end
    if (wrHit && addr == TSR_OFS_PERIODIC_CTRL) begin
      next_s.rate      = wdata[TSR_POS_RATE +: 3];
      next_s.fastStart = wdata[TSR_BIT_FAST_START];
    end
    if (wrHit && addr == TSR_OFS_OPTIONS) begin
      next_s.options = wdata[15:0];
    end

    if (wrHit && cmdWdClr) begin
      next_s.wdCount   = 16'h0000;
      next_s.powerdown = 1'b0;
    end

    irqReady = (s.tickEn & s.tickFlag) | (s.periodicEn & s.periodicFlag);
    irqReady = irqReady & s.sharedEn & s.sharedFlag;

    unique case (s.mode)
      TSR_RUN: begin
        // watchdog timeout in run: expired set, powerdown kept
        if (wdOverflow) begin
          next_s.expired  = 1'b1;
          next_s.wdCount  = 16'h0000;
          next_s.chain    = '0;
          next_s.core.vector = TSR_RESET_VECTOR;
          next_s.mode     = TSR_START;
          next_s.startCount = 11'h000;
          next_s.resumeIrq  = 1'b0;
        end else if (wrHit && cmdSleep) begin
          next_s.mode = TSR_SLEEP;
          next_s.wdCount = 16'h0000;
          next_s.powerdown = 1'b1;
          next_s.expired   = 1'b0;
          next_s.pendTickAtSleep = s.tickFlag;
          next_s.pendPerAtSleep  = s.periodicFlag;
        end else if (irqReady && !s.core.irqCall) begin
          next_s.core.irqCall = 1'b1;
          next_s.core.vector  = TSR_IRQ_VECTOR;
          // Service takes the shared flag, else the core is called again every second cycle
          next_s.sharedFlag   = next_s.tickOut | next_s.periodicOut;
        end
      end
      TSR_SLEEP: begin
        portWake = |(wakeMask & s.portAPrev & ~portSync);
        // only fresh flags wake the device
        tickWake = next_s.tickFlag & ~s.pendTickAtSleep;
        perWake  = next_s.periodicFlag & ~s.pendPerAtSleep;
        if (wdOverflow) begin
          next_s.expired   = 1'b1;
          next_s.warm      = 1'b1;
          next_s.wdCount   = 16'h0000;
          next_s.mode      = TSR_START;
          next_s.startCount = 11'h000;
          next_s.resumeIrq  = 1'b0;
        end else if (portWake || tickWake || perWake) begin
          // call only if enabled, else next instruction
          next_s.resumeIrq  = (tickWake & s.tickEn) | (perWake & s.periodicEn);
          next_s.mode       = TSR_START;
          next_s.startCount = 11'h000;
        end
      end
      TSR_START: begin
        // start-up delay of 1024 system clocks
        // counter runs on restarted system clock, holds fetch
        next_s.startCount = s.startCount + 11'h001;
        if (s.startCount == 11'(TSR_STARTUP_CYC - 1)) begin
          next_s.mode = TSR_RUN;
          next_s.core.warmReset = s.warm;
          next_s.warm = 1'b0;
          if (s.resumeIrq && s.sharedEn) begin
            next_s.core.irqCall = 1'b1;
            next_s.core.vector  = TSR_IRQ_VECTOR;
            next_s.sharedFlag   = next_s.tickOut | next_s.periodicOut;
          end
        end
      end
      default: next_s.mode = TSR_START;
    endcase

    // external clear: full reset of the chain and vector
    if (clrLow) begin
      // clear from sleep gives expired 0, powerdown 1
      if (s.mode == TSR_SLEEP) begin
        next_s.expired   = 1'b0;
        next_s.powerdown = 1'b1;
      end
      next_s.chain      = '0;
      next_s.wdCount    = 16'h0000;
      next_s.tickEn     = 1'b0;
      next_s.periodicEn = 1'b0;
      next_s.sharedEn   = 1'b0;
      next_s.tickFlag   = 1'b0;
      next_s.periodicFlag = 1'b0;
      next_s.sharedFlag = 1'b0;
      next_s.rate       = TSR_RST_RATE;
      next_s.fastStart  = 1'b0;
      next_s.warm       = 1'b0;
      next_s.resumeIrq  = 1'b0;
      next_s.core.irqCall = 1'b0;
      next_s.core.vector  = TSR_RESET_VECTOR;
      next_s.mode       = TSR_START;
      next_s.startCount = 11'h000;
    end

    // fetch held outside the run state
    next_s.core.hold = (next_s.mode != TSR_RUN);

    // Read port: data valid the cycle after the strobe
    next_s.rdata = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        TSR_OFS_SHARED_IRQ_CTRL: begin
          next_s.rdata[TSR_BIT_TICK_EN]       = s.tickEn;
          next_s.rdata[TSR_BIT_PERIODIC_EN]   = s.periodicEn;
          next_s.rdata[TSR_BIT_TICK_FLAG]     = s.tickFlag;
          next_s.rdata[TSR_BIT_PERIODIC_FLAG] = s.periodicFlag;
        end
        TSR_OFS_IRQ_CTRL_SECOND: begin
          next_s.rdata[TSR_BIT_SHARED_EN]   = s.sharedEn;
          next_s.rdata[TSR_BIT_SHARED_FLAG] = s.sharedFlag;
        end
        TSR_OFS_PERIODIC_CTRL: begin
          next_s.rdata[TSR_POS_RATE +: 3]   = s.rate;
          next_s.rdata[TSR_BIT_FAST_START]  = s.fastStart;
        end
        TSR_OFS_STATUS: begin
          next_s.rdata[TSR_BIT_POWERDOWN] = s.powerdown;
          next_s.rdata[TSR_BIT_EXPIRED]   = s.expired;
          next_s.rdata[TSR_BIT_SLEEPING]  = (s.mode == TSR_SLEEP);
          next_s.rdata[TSR_BIT_STARTING]  = (s.mode == TSR_START);
        end
        TSR_OFS_OPTIONS: begin
          next_s.rdata[15:0] = s.options;
          next_s.rdata[TSR_POS_WAKEMASK +: 8] = portSel;
        end
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  // power-on reset: all cleared except mode, rate, portAPrev and hold, start-up delay first
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.mode <= TSR_START;
      s.rate <= TSR_RST_RATE;
      s.portAPrev <= 8'hff;
      s.core.hold <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from state flops; sysOscEnable is decoded from the mode
  assign rdata         = s.rdata;
  assign sysOscEnable  = (s.mode != TSR_SLEEP);
  assign fastStartOsc  = s.fastStart;
  assign tickPulse     = s.tickOut;
  assign periodicPulse = s.periodicOut;
  assign dispClk       = s.dispClk;
  assign buzzClk       = s.buzzClk;
  assign coreHold      = s.core.hold;
  assign coreWarmReset = s.core.warmReset;
  assign coreIrqCall   = s.core.irqCall;
  assign coreVector    = s.core.vector;
endmodule

// ### tsr_unit_checker.sv
// Port-level checks for the timebase, sleep and reset unit
`timescale 1ns/1ps
module tsr_unit_checker
  import tsr_pkg::*;
(
  input wire logic        mclk,          // Clock
  input wire logic        rst,           // Reset
  input wire logic        extClearN,     // Clear pin
  input wire logic [3:0]  addr,          // Address
  input wire logic [31:0] wdata,         // Write data
  input wire logic        wr,            // Write
  input wire logic        rd,            // Read
  input wire logic [31:0] rdata,         // Read data
  input wire logic        sysOscEnable,  // Oscillator on
  input wire logic        fastStartOsc,  // Fast start
  input wire logic        tickPulse,     // Tick
  input wire logic        periodicPulse, // Periodic
  input wire logic        coreHold,      // Fetch hold
  input wire logic        coreWarmReset, // Warm reset
  input wire logic        coreIrqCall,   // Irq call
  input wire logic [15:0] coreVector     // Vector
);
  logic [11:0] runCnt; // Held cycles with the oscillator up

  // Clear pin restarts the count, its synchroniser adds a few cycles
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      runCnt <= 12'h000;
    else if (!coreHold || !sysOscEnable || !extClearN)
      runCnt <= 12'h000;
    else if (runCnt != 12'hfff)
      runCnt <= runCnt + 12'h001;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_tick_gap: assert property (tickPulse |=> !tickPulse [*8])
    else $error("tick pulse repeated too soon");
  chk_periodic_gap: assert property (periodicPulse |=> !periodicPulse [*8])
    else $error("periodic pulse repeated too soon");
  chk_irq_vector: assert property (coreIrqCall |-> coreVector == TSR_IRQ_VECTOR)
    else $error("interrupt call with wrong vector");
  chk_sleep_stop: assert property (wr && addr == 4'h4 && wdata[0] && !coreHold |=> !sysOscEnable)
    else $error("oscillator still on after sleep");
  chk_sleep_hold: assert property (!sysOscEnable |-> coreHold)
    else $error("fetch not held while oscillator is off");
  chk_start_len: assert property ($fell(coreHold) |-> runCnt >= 12'h3ff && runCnt <= 12'h406)
    else $error("start-up delay of wrong length");
  chk_warm_end: assert property (coreWarmReset |-> $past(coreHold) && !coreIrqCall)
    else $error("warm reset outside start-up end");
  chk_clear_hold: assert property ($fell(extClearN) |-> ##[1:4] coreHold)
    else $error("external clear did not hold fetch");
  chk_fast_read: assert property ($past(rd) && $past(addr) == 4'h2 |-> rdata[4] == fastStartOsc)
    else $error("fast-start output differs from its bit");

  cover property (coreIrqCall);
  cover property (coreWarmReset);
  cover property ($rose(sysOscEnable));
endmodule

bind tsr_unit tsr_unit_checker tsr_unit_checker_i (
  .mclk(mclk), .rst(rst), .extClearN(extClearN), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .sysOscEnable(sysOscEnable), .fastStartOsc(fastStartOsc), .tickPulse(tickPulse),
  .periodicPulse(periodicPulse), .coreHold(coreHold), .coreWarmReset(coreWarmReset),
  .coreIrqCall(coreIrqCall), .coreVector(coreVector)
);

// ### tsr_core_model.sv
// Behavioural model of the processor core facing the unit
`timescale 1ns/1ps
module tsr_core_model
  import tsr_pkg::*;
(
  input  wire logic        mclk,          // Clock
  input  wire logic        rst,           // Reset
  input  wire logic        coreHold,      // Fetch hold
  input  wire logic        coreWarmReset, // Warm reset
  input  wire logic        coreIrqCall,   // Irq call
  input  wire logic [15:0] coreVector,    // Vector
  output logic      [15:0] pc,            // Program counter
  output int               calls,         // Calls taken
  output int               warms          // Warm resets taken
);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc <= 16'h0000;
      calls <= 0;
      warms <= 0;
    end else if (coreWarmReset) begin
      pc <= 16'h0000;
      warms <= warms + 1;
    end else if (coreIrqCall) begin
      pc <= coreVector;
      calls <= calls + 1;
    end else if (!coreHold)
      pc <= pc + 16'h0001;
  end
endmodule

// ### tsr_unit_tb_top.sv
// Self-checking bench for the timebase, sleep and reset unit
`timescale 1ns/1ps
module tsr_unit_tb_top;
  logic        mclk, rst, extClearN, wr, rd, running;
  logic [2:0]  wdDiv;
  logic [7:0]  portA;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, v;
  logic        sysOscEnable, fastStartOsc, tickPulse, periodicPulse, dispClk, buzzClk;
  logic        coreHold, coreWarmReset, coreIrqCall;
  logic [15:0] coreVector, pc;
  int          calls, warms, badCount, samplesChecked, n;

  // System clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Slow oscillator at an eighth of the system clock
  always @(posedge mclk or posedge rst) begin
    if (rst)
      wdDiv <= 3'h0;
    else
      wdDiv <= wdDiv + 3'h1;
  end
  assign running = ~coreHold;

  tsr_unit tsr_unit_i (
    .mclk(mclk), .rst(rst), .wdOscTick(wdDiv[2]), .rtOscTick(1'b0), .extClearN(extClearN), .portA(portA),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sysOscEnable(sysOscEnable),
    .fastStartOsc(fastStartOsc), .tickPulse(tickPulse), .periodicPulse(periodicPulse), .dispClk(dispClk),
    .buzzClk(buzzClk), .coreHold(coreHold), .coreWarmReset(coreWarmReset), .coreIrqCall(coreIrqCall),
    .coreVector(coreVector));
  tsr_core_model tsr_core_model_i (
    .mclk(mclk), .rst(rst), .coreHold(coreHold), .coreWarmReset(coreWarmReset), .coreIrqCall(coreIrqCall),
    .coreVector(coreVector), .pc(pc), .calls(calls), .warms(warms));

  task automatic conclude();
    $display("Checks made %0d, mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // Cycles until the next rising level, bounded
  task automatic rise(ref logic s, input int lim);
    #1;
    n = 0;
    while (s === 1'b1 && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (s !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= lim) begin
      badCount++;
      $display("BAD wait expected edge seen none");
      conclude();
    end
  endtask
  task automatic gap(ref logic s, input int exp, input int tol, input string what);
    rise(s, 4 * exp);
    rise(s, 4 * exp);
    chk(what, 32'(exp), (n >= exp - tol && n <= exp + tol) ? 32'(exp) : 32'(n));
  endtask

  task automatic t_reset();
    rise(running, 1200);
    chk("start delay", 32'h1, 32'(n >= 1022 && n <= 1030));
    rdr(4'h2);
    chk("rate reset", 32'h7, 32'(v[4:0]));
    rdr(4'h3);
    chk("cause flags", 32'h0, 32'(v[1:0]));
    chk("vector", 32'h0, 32'(coreVector));
  endtask
  // Instruction clock source, boundary taps of tick, periodic and buzzer, display tap 6
  task automatic t_chain();
    wrr(4'h4, 32'h2);
    wrr(4'h5, 32'h0001_1f62);
    wrr(4'h2, 32'h0);
    gap(periodicPulse, 1024, 0, "periodic gap");
    gap(dispClk, 1024, 0, "display gap");
    gap(buzzClk, 2048, 0, "buzzer gap");
    gap(tickPulse, 16384, 0, "tick gap");
    rdr(4'h0);
    chk("tick flags", 32'h3, 32'(v[6:5]));
    rdr(4'h1);
    chk("shared flag", 32'h1, 32'(v[6]));
  endtask
  task automatic t_irq();
    wrr(4'h0, 32'h0);
    wrr(4'h1, 32'h0);
    wrr(4'h0, 32'h4);
    wrr(4'h1, 32'h4);
    rise(coreIrqCall, 2100);
    chk("irq vector", 32'h18, 32'(coreVector));
    // The core model counts the call on the following edge
    @(posedge mclk);
    #1;
    chk("calls", 32'h1, 32'(calls));
    rdr(4'h0);
    chk("periodic flag", 32'h1, 32'(v[6]));
    wrr(4'h0, 32'h0);
    wrr(4'h1, 32'h0);
  endtask
  // Instruction clock stops in sleep, so only the pin may wake
  task automatic t_portwake();
    wrr(4'h4, 32'h2);
    wrr(4'h4, 32'h1);
    rdr(4'h3);
    chk("osc stopped", 32'h0, 32'(sysOscEnable));
    chk("sleep status", 32'h5, 32'(v[2:0]));
    portA <= 8'hfe;
    rise(running, 1200);
    chk("wake delay", 32'h1, 32'(n >= 1024 && n <= 1034));
    chk("no call", 32'h1, 32'(calls));
    portA <= 8'hff;
  endtask
  task automatic t_extclear();
    wrr(4'h2, 32'h10);
    rdr(4'h2);
    chk("fast start", 32'h3, 32'({v[4], fastStartOsc}));
    extClearN <= 1'b0;
    repeat (6) @(posedge mclk);
    extClearN <= 1'b1;
    rise(running, 1200);
    rdr(4'h2);
    chk("rate after clear", 32'h7, 32'(v[4:0]));
    rdr(4'h3);
    chk("clear causes", 32'h1, 32'(v[1:0]));
    wrr(4'h4, 32'h2);
    rdr(4'h3);
    chk("powerdown clear", 32'h0, 32'(v[1:0]));
  endtask
  // Periodic flag left pending before sleep; tick slowest so only the watchdog wakes
  task automatic t_wdwake();
    wrr(4'h2, 32'h0);
    rise(periodicPulse, 2100);
    wrr(4'h5, 32'h6c);
    wrr(4'h4, 32'h2);
    wrr(4'h4, 32'h1);
    gap(dispClk, 2048, 2, "sleep display");
    rise(coreWarmReset, 40000);
    @(posedge mclk);
    #1;
    chk("warm count", 32'h1, 32'(warms));
    chk("warm pc", 32'h0, 32'(pc));
    rdr(4'h3);
    chk("watchdog wake", 32'h3, 32'(v[1:0]));
  endtask

  initial begin
    rst = 1'b1;
    extClearN = 1'b1;
    portA = 8'hff;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    badCount = 0;
    samplesChecked = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_chain();
    t_irq();
    t_portwake();
    t_extclear();
    t_wdwake();
    conclude();
  end
endmodule
